/* File: include/fetch_pkg.sv */
// Shared constants and carrier types for the fetch pipeline and data address unit
package fetch_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int PC_W       = 21;
   localparam int WORD_W     = 16;
   localparam int DADDR_W    = 12;
   localparam int BANK_W     = 4;
   localparam int OFS_W      = 8;
   localparam int BRANCH_W   = 11;
   localparam int OPER_W     = 12;
   // ------------------------------------------------------------
   // Data memory map
   // ------------------------------------------------------------
   localparam logic [DADDR_W-1:0] SFR_TOP        = 12'hfff;
   localparam logic [DADDR_W-1:0] SFR_BASE       = 12'hf80;
   localparam logic [DADDR_W-1:0] GPR_SIZE_DEF   = 12'h100;
   localparam logic [OFS_W-1:0]   ACCESS_SPLIT   = 8'h80;
   localparam logic [BANK_W-1:0]  ACCESS_HI_BANK = 4'hf;
   localparam logic [BANK_W-1:0]  ACCESS_LO_BANK = 4'h0;
   localparam logic [DADDR_W-1:0] PCL_ADDR       = 12'hff9;
   // Second word of a two-word instruction carries ones in its top nibble
   localparam logic [3:0]         SECOND_TAG     = 4'hf;
   localparam logic [PC_W-1:0]    PC_STEP        = 21'h000002;
   localparam logic [PC_W-1:0]    RESET_VECTOR   = 21'h000000;
   localparam logic [WORD_W-1:0]  NOP_WORD       = 16'h0000;
   localparam logic [7:0]         ZERO_BYTE      = 8'h00;

   // Phase of the instruction cycle, one-hot
   typedef enum logic [3:0] {
      PH_ONE   = 4'b0001,
      PH_TWO   = 4'b0010,
      PH_THREE = 4'b0100,
      PH_FOUR  = 4'b1000
   } phase_t;

   // Program change requested by the decoder for the current instruction
   typedef enum logic [2:0] {
      CH_NONE     = 3'b000,
      CH_ABSOLUTE = 3'b001,
      CH_RELATIVE = 3'b010,
      CH_PCL      = 3'b011,
      CH_SKIP     = 3'b100
   } change_t;

   // Decoder request bundle
   typedef struct packed {
      change_t               kind;
      logic [PC_W-2:0]       word_target;
      logic [BRANCH_W-1:0]   offset;
      logic [7:0]            pcl_value;
      logic                  two_word;
   } branch_req_t;

   // Data access request bundle
   typedef struct packed {
      logic                  rd;
      logic                  wr;
      logic                  access;
      logic                  indirect;
      logic                  full;
      logic [1:0]            ptr_sel;
      logic [OFS_W-1:0]      offset;
      logic [DADDR_W-1:0]    full_addr;
      logic [7:0]            wdata;
   } data_req_t;
endpackage : fetch_pkg

/* File: verilog/data_addr_unit.sv */
// Data memory address formation and unimplemented-location read masking
`timescale 1ns/1ps
module data_addr_unit #(
   parameter logic [7:0]  ACCESS_BOUND = fetch_pkg::ACCESS_SPLIT,
   parameter logic [11:0] GPR_SIZE     = fetch_pkg::GPR_SIZE_DEF
) (
   input  wire fetch_pkg::data_req_t  req_i,
   input  wire logic [3:0]            bank_i,
   input  wire logic [35:0]           ptrs_i,
   input  wire logic [7:0]            ram_rdata_i,
   output logic [11:0]                addr_o,
   output logic [7:0]                 rdata_o
);
   import fetch_pkg::*;

   logic [DADDR_W-1:0] ptr_sel;
   logic               implemented;

   // ------------------------------------------------------------
   // Address mux: full, pointer, access bank or banked
   // ------------------------------------------------------------
   always_comb begin
      ptr_sel = ptrs_i[req_i.ptr_sel*DADDR_W +: DADDR_W];
      if (req_i.full) begin
         addr_o = req_i.full_addr;
      end else if (req_i.indirect) begin
         addr_o = ptr_sel;
      end else if (req_i.access) begin
         // Low offsets hit bank 0, high offsets hit bank 15
         addr_o = (req_i.offset < ACCESS_BOUND) ?
                  {ACCESS_LO_BANK, req_i.offset} :
                  {ACCESS_HI_BANK, req_i.offset};
      end else begin
         addr_o = {bank_i, req_i.offset};
      end
   end

   // Holes between the general area and the special area read zero
   always_comb begin
      implemented = (addr_o < GPR_SIZE) || (addr_o >= SFR_BASE);
      rdata_o     = implemented ? ram_rdata_i : ZERO_BYTE;
   end
endmodule : data_addr_unit

/* File: verilog/fetch_pipeline.sv */
// Four-phase fetch/execute sequencer with program counter and data access control
`timescale 1ns/1ps
// Behaviour
// - Clock divided by four into four one-hot non-overlapping phases per cycle.
// - Program counter advances in phase one; instruction latched in phase four.
// - Next fetch overlaps current execute; one instruction per cycle.
// - Program counter changes cost two cycles; prefetched word is flushed.
// - Decode in phases two to four; read in two, write in four.
// - Program memory byte addressed; instruction words at even addresses.
// - Sequential step is two; counter bit zero always zero.
// - Absolute target word address loads counter bits 20 down to 1.
// - Relative offset counts single-word instructions, two bytes each.
// - Second word has top nibble ones, is a no-op, supplies 12 bits.
// - Second word executed alone after a skip behaves as a no-op.
// - Table transfers move one byte via table pointer and table latch.
// - Data memory uses a 12-bit address covering 4096 bytes.
// - Sixteen banks of 256; bank select low nibble only implemented.
// - Special registers F80h to FFFh; general registers from zero upward.
// - Unimplemented data addresses read as zero.
// - Indirect pointers hold 12-bit addresses, bypassing bank select.
// - Access bank reachable in one cycle regardless of bank select.
// - Register-to-register move takes two words, two cycles, full addresses.
// - General registers are never initialised or cleared by reset.
// - Counter low byte write loads upper bits from holding registers.
module fetch_pipeline #(
   parameter logic [7:0]  ACCESS_BOUND = fetch_pkg::ACCESS_SPLIT,
   parameter logic [11:0] GPR_SIZE     = fetch_pkg::GPR_SIZE_DEF
) (
   input  wire logic                       CLK_SYS_I,
   input  wire logic                       RESET_I,
   input  wire logic [15:0]                PROG_WORD_I,
   input  wire logic [7:0]                 PROG_BYTE_I,
   input  wire fetch_pkg::branch_req_t     BRANCH_REQ_I,
   input  wire fetch_pkg::data_req_t       DATA_REQ_I,
   input  wire logic [7:0]                 PC_HIGH_HOLDING_I,
   input  wire logic [4:0]                 PC_UPPER_HOLDING_I,
   input  wire logic [3:0]                 BANK_SELECT_I,
   input  wire logic [35:0]                INDIRECT_POINTER_I,
   input  wire logic                       TABLE_RD_I,
   input  wire logic [20:0]                TABLE_POINTER_I,
   input  wire logic [7:0]                 RAM_RDATA_I,
   output logic [20:0]                     PROG_ADDR_O,
   output logic [3:0]                      PHASE_O,
   output logic [15:0]                     INSTRUCTION_LATCH_O,
   output logic                            EXEC_VALID_O,
   output logic [11:0]                     SECOND_OPERAND_O,
   output logic [11:0]                     RAM_ADDR_O,
   output logic                            RAM_RD_O,
   output logic                            RAM_WR_O,
   output logic [7:0]                      RAM_WDATA_O,
   output logic [7:0]                      OPERAND_O,
   output logic [7:0]                      TABLE_LATCH_O
);
   import fetch_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   phase_t              phase_q;
   logic [PC_W-1:0]     pc_q;
   logic [PC_W-1:0]     pc_d;
   logic [WORD_W-1:0]   fetch_q;       // Word fetched, waiting to execute
   logic                fetch_ok_q;    // Fetch register holds a usable word
   logic [WORD_W-1:0]   ir_q;
   logic                exec_q;
   logic                skip_next_q;   // Next executed word is to be dropped
   logic [OPER_W-1:0]   oper_q;
   logic [DADDR_W-1:0]  ram_addr_q;
   logic                ram_rd_q;
   logic                ram_wr_q;
   logic [7:0]          ram_wdata_q;
   logic [7:0]          operand_q;
   logic [7:0]          tlatch_q;
   logic [DADDR_W-1:0]  dau_addr;
   logic [7:0]          dau_rdata;
   logic                flush;

   // Word-address arithmetic, shared by the sequential and relative branch paths
   function automatic logic [PC_W-1:0] word_add(input logic [PC_W-1:0] pc,
                                                input logic [PC_W-1:0] bytes);
      word_add = (pc + bytes) & ~PC_W'(1);
   endfunction : word_add

   function automatic logic is_second_word(input logic [WORD_W-1:0] w);
      is_second_word = (w[WORD_W-1 -: 4] == SECOND_TAG);
   endfunction : is_second_word

   // ------------------------------------------------------------
   // Phase generator
   // ------------------------------------------------------------
   // Ring counter keeps the phases one-hot and glitch free
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         phase_q <= PH_ONE;
      end else begin
         case (phase_q)
            PH_ONE:   phase_q <= PH_TWO;
            PH_TWO:   phase_q <= PH_THREE;
            PH_THREE: phase_q <= PH_FOUR;
            PH_FOUR:  phase_q <= PH_ONE;
            default:  phase_q <= PH_ONE;
         endcase
      end
   end

   chk_phase_ring: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      phase_q == PH_ONE |=> phase_q == PH_TWO ##1 phase_q == PH_THREE
      ##1 phase_q == PH_FOUR ##1 phase_q == PH_ONE)
      else $error("phase ring broken");

   // A ring that picks up a second bit would fire two phases at once
   chk_phase_onehot: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      $onehot(phase_q))
      else $error("phase register not one-hot");

   // ------------------------------------------------------------
   // Program counter
   // ------------------------------------------------------------
   // A change requested by the executing word lands at the end of phase four
   // so the next phase one fetches from the target.
   assign flush = exec_q && (phase_q == PH_FOUR) && (BRANCH_REQ_I.kind != CH_NONE)
                  && (BRANCH_REQ_I.kind != CH_SKIP);

   always_comb begin
      pc_d = pc_q;
      if (phase_q == PH_ONE) begin
         pc_d = word_add(pc_q, PC_STEP);
      end else if (flush) begin
         case (BRANCH_REQ_I.kind)
            CH_ABSOLUTE: pc_d = {BRANCH_REQ_I.word_target, 1'b0};
            CH_RELATIVE: pc_d = word_add(pc_q,
                  PC_W'({{(PC_W-BRANCH_W-1){BRANCH_REQ_I.offset[BRANCH_W-1]}},
                         BRANCH_REQ_I.offset, 1'b0}));
            // Low byte write pulls in the holding registers; bit 0 stays clear
            CH_PCL:      pc_d = {PC_UPPER_HOLDING_I, PC_HIGH_HOLDING_I,
                                 BRANCH_REQ_I.pcl_value[7:1], 1'b0};
            default:     pc_d = pc_q;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         pc_q <= RESET_VECTOR;
      end else begin
         pc_q <= pc_d;
      end
   end

   // Address presented to program memory is the pre-increment value
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         PROG_ADDR_O <= RESET_VECTOR;
      end else if (phase_q == PH_ONE) begin
         PROG_ADDR_O <= pc_q;
      end
   end

   chk_pc_even: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      pc_q[0] == 1'b0 && PROG_ADDR_O[0] == 1'b0)
      else $error("program counter misaligned");

   chk_pc_step: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      phase_q == PH_ONE |=> pc_q == $past(pc_q) + PC_STEP)
      else $error("counter did not step by two");

   chk_pcl_load: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      flush && BRANCH_REQ_I.kind == CH_PCL |=>
      pc_q[20:8] == {$past(PC_UPPER_HOLDING_I), $past(PC_HIGH_HOLDING_I)})
      else $error("holding registers not loaded");

   chk_abs_load: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      flush && BRANCH_REQ_I.kind == CH_ABSOLUTE |=>
      pc_q == {$past(BRANCH_REQ_I.word_target), 1'b0})
      else $error("absolute target not loaded");

   // The fetch address moves only at phase one, even while a branch lands
   chk_addr_hold: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      phase_q != PH_ONE |=> $stable(PROG_ADDR_O))
      else $error("fetch address moved outside phase one");

   // ------------------------------------------------------------
   // Fetch and instruction latch
   // ------------------------------------------------------------
   // Fetch register fills in phase four; a program change flushes the word
   // just fetched so the target is fetched during the dead cycle.
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         fetch_q    <= NOP_WORD;
         fetch_ok_q <= 1'b0;
      end else if (phase_q == PH_FOUR) begin
         fetch_q    <= PROG_WORD_I;
         fetch_ok_q <= !flush;
      end
   end

   // Second-word operand is caught from any word fetched in phase four whose top nibble is ones
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         oper_q <= '0;
      end else if (phase_q == PH_FOUR && is_second_word(PROG_WORD_I)) begin
         oper_q <= PROG_WORD_I[OPER_W-1:0];
      end
   end

   // Skip flag: set by a true conditional skip, consumed by the next word
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         skip_next_q <= 1'b0;
      end else if (phase_q == PH_FOUR && exec_q && BRANCH_REQ_I.kind == CH_SKIP) begin
         skip_next_q <= 1'b1;
      end else if (phase_q == PH_FOUR) begin
         skip_next_q <= 1'b0;
      end
   end

   // Execute stage moves the prefetched word in at phase one of the next cycle.
   // A skipped word, a flushed slot or a lone second word executes as a no-op.
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         ir_q   <= NOP_WORD;
         exec_q <= 1'b0;
      end else if (phase_q == PH_ONE) begin
         ir_q   <= fetch_q;
         exec_q <= fetch_ok_q && !skip_next_q && !is_second_word(fetch_q);
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         INSTRUCTION_LATCH_O <= NOP_WORD;
         EXEC_VALID_O        <= 1'b0;
         SECOND_OPERAND_O    <= '0;
         PHASE_O             <= PH_ONE;
      end else begin
         INSTRUCTION_LATCH_O <= ir_q;
         EXEC_VALID_O        <= exec_q;
         SECOND_OPERAND_O    <= oper_q;
         PHASE_O             <= phase_q;
      end
   end

   chk_flush_bubble: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      flush |=> ##1 exec_q == 1'b0)
      else $error("flushed word was executed");

   chk_lone_second: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      phase_q == PH_ONE && is_second_word(fetch_q) |=> !exec_q)
      else $error("second word executed alone");

   chk_skip_drop: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      phase_q == PH_ONE && skip_next_q |=> !exec_q)
      else $error("skipped word was executed");

   // Execute stage must hold its word for the whole cycle so decode sees one value
   chk_ir_hold: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      phase_q != PH_ONE |=> $stable(ir_q) && $stable(exec_q))
      else $error("execute stage changed mid cycle");

   chk_fetch_hold: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      phase_q != PH_FOUR |=> $stable(fetch_q))
      else $error("fetch register changed outside phase four");

   // ------------------------------------------------------------
   // Data access: read in phase two, write in phase four
   // ------------------------------------------------------------
   data_addr_unit #(
      .ACCESS_BOUND (ACCESS_BOUND),
      .GPR_SIZE     (GPR_SIZE)
   ) u_dau (
      .req_i        (DATA_REQ_I),
      .bank_i       (BANK_SELECT_I),
      .ptrs_i       (INDIRECT_POINTER_I),
      .ram_rdata_i  (RAM_RDATA_I),
      .addr_o       (dau_addr),
      .rdata_o      (dau_rdata)
   );

   // Strobes are registered so the RAM sees them during the right phase.
   // General registers live in the external RAM and are never touched here.
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         ram_addr_q  <= '0;
         ram_rd_q    <= 1'b0;
         ram_wr_q    <= 1'b0;
         ram_wdata_q <= ZERO_BYTE;
      end else begin
         ram_addr_q  <= dau_addr;
         ram_rd_q    <= exec_q && DATA_REQ_I.rd && (phase_q == PH_ONE);
         ram_wr_q    <= exec_q && DATA_REQ_I.wr && (phase_q == PH_THREE);
         ram_wdata_q <= DATA_REQ_I.wdata;
      end
   end

   // Operand captured when the read strobe is up
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         operand_q <= ZERO_BYTE;
      end else if (ram_rd_q) begin
         operand_q <= dau_rdata;
      end
   end

   assign RAM_ADDR_O  = ram_addr_q;
   assign RAM_RD_O    = ram_rd_q;
   assign RAM_WR_O    = ram_wr_q;
   assign RAM_WDATA_O = ram_wdata_q;
   assign OPERAND_O   = operand_q;

   chk_read_phase: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      ram_rd_q |-> phase_q == PH_TWO)
      else $error("read outside phase two");

   chk_write_phase: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      ram_wr_q |-> phase_q == PH_FOUR)
      else $error("write outside phase four");

   // A bubble or a dropped word must never touch the data memory
   chk_idle_no_strobe: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      !exec_q |=> !ram_rd_q && !ram_wr_q)
      else $error("strobe from a slot that does not execute");

   // ------------------------------------------------------------
   // Table latch: one byte per transfer
   // ------------------------------------------------------------
   // Byte from the table pointer address lands at phase four of the read
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         tlatch_q <= ZERO_BYTE;
      end else if (TABLE_RD_I && exec_q && phase_q == PH_FOUR) begin
         tlatch_q <= PROG_BYTE_I;
      end
   end

   assign TABLE_LATCH_O = tlatch_q;

   chk_table_hold: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      !(TABLE_RD_I && exec_q && phase_q == PH_FOUR) |=> $stable(tlatch_q))
      else $error("table latch changed without a read");

   // Table pointer is owned by the datapath; its value only feeds the unused sink here
   logic unused_tp;
   assign unused_tp = ^TABLE_POINTER_I ^ BRANCH_REQ_I.two_word;
endmodule : fetch_pipeline

/* File: tb/prog_data_mem.sv */
// Program memory and data RAM arrays facing the fetch pipeline
`timescale 1ns/1ps
module prog_data_mem (
   input  wire logic        clk_i,
   input  wire logic [20:0] prog_addr_i,
   input  wire logic [20:0] tbl_ptr_i,
   input  wire logic [11:0] ram_addr_i,
   input  wire logic        ram_wr_i,
   input  wire logic [7:0]  ram_wdata_i,
   output logic      [15:0] prog_word_o,
   output logic      [7:0]  prog_byte_o,
   output logic      [7:0]  ram_rdata_o
);
   // ----------
   // Arrays
   // ----------
   logic [7:0]  ram [4096];
   logic [15:0] tw;
   // Word image: low field is the word index, top nibble f marks second words
   function automatic logic [15:0] img(input logic [11:0] f);
      return {(f[3:0] == 4'h7) ? 4'hf : 4'h1, f};
   endfunction : img
   // No reset at all; seeded never zero so read masking is visible
   initial begin
      for (int a = 0; a < 4096; a++) begin
         ram[a] = 8'(a) ^ 8'(a >> 4) | 8'h01;
      end
   end
   assign prog_word_o = img(prog_addr_i[12:1]);
   assign tw          = img(tbl_ptr_i[12:1]);
   // Low byte of a word sits at the even byte address
   assign prog_byte_o = tbl_ptr_i[0] ? tw[15:8] : tw[7:0];
   assign ram_rdata_o = ram[ram_addr_i];
   // Writes land on the edge that ends the write strobe cycle
   always @(posedge clk_i) begin
      if (ram_wr_i) begin
         ram[ram_addr_i] <= ram_wdata_i;
      end
   end
endmodule : prog_data_mem

/* File: tb/cpu_fetch_pipeline_and_memory_map_tb.sv */
// Self-checking bench for the fetch pipeline and data address path
`timescale 1ns/1ps
module cpu_fetch_pipeline_and_memory_map_tb;
   import fetch_pkg::*;
   // ----------
   // Signals
   // ----------
   localparam logic [7:0]  AB  = 8'h60;
   localparam logic [11:0] GENERAL_PURPOSE_REGS = 12'h180;
   logic        clk, rst, tbl_rd, rd_o, wr_o, xv, op_due;
   logic [15:0] pw, il, last_w, tw;
   logic [7:0]  pb, hh, rdat, wd, op, tl, exp_op;
   logic [4:0]  uh;
   logic [3:0]  bank, bank1, ph, ph_q;
   logic [35:0] ptrs, ptrs1;
   logic [20:0] tp, pa, pa_q;
   logic [11:0] so, ra, ex_a, exp_f;
   branch_req_t br;
   data_req_t   dq, dq1;
   change_t     kinds [4];
   int          n_mismatch, cmp_count, cyc, seed, last_c, gap, n_exec, nb, rd_ph, sec_f, brk_c;
   // 40 MHz system clock
   initial begin
      clk = 1'b0;
      forever begin
         #12.5 clk = ~clk;
      end
   end
   fetch_pipeline #(
      .ACCESS_BOUND (AB),
      .GPR_SIZE     (GENERAL_PURPOSE_REGS)
   ) dut_u (
      .CLK_SYS_I           (clk),
      .RESET_I             (rst),
      .PROG_WORD_I         (pw),
      .PROG_BYTE_I         (pb),
      .BRANCH_REQ_I        (br),
      .DATA_REQ_I          (dq),
      .PC_HIGH_HOLDING_I   (hh),
      .PC_UPPER_HOLDING_I  (uh),
      .BANK_SELECT_I       (bank),
      .INDIRECT_POINTER_I  (ptrs),
      .TABLE_RD_I          (tbl_rd),
      .TABLE_POINTER_I     (tp),
      .RAM_RDATA_I         (rdat),
      .PROG_ADDR_O         (pa),
      .PHASE_O             (ph),
      .INSTRUCTION_LATCH_O (il),
      .EXEC_VALID_O        (xv),
      .SECOND_OPERAND_O    (so),
      .RAM_ADDR_O          (ra),
      .RAM_RD_O            (rd_o),
      .RAM_WR_O            (wr_o),
      .RAM_WDATA_O         (wd),
      .OPERAND_O           (op),
      .TABLE_LATCH_O       (tl)
   );
   prog_data_mem mem_u (
      .clk_i       (clk),
      .prog_addr_i (pa),
      .tbl_ptr_i   (tp),
      .ram_addr_i  (ra),
      .ram_wr_i    (wr_o),
      .ram_wdata_i (wd),
      .prog_word_o (pw),
      .prog_byte_o (pb),
      .ram_rdata_o (rdat)
   );
   // ----------
   // Helpers
   // ----------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   function automatic logic [15:0] exp_word(input logic [11:0] f);
      return {(f[3:0] == 4'h7) ? 4'hf : 4'h1, f};
   endfunction : exp_word
   // Data address as the addressing mode should form it
   function automatic logic [11:0] ea(input data_req_t q, input logic [3:0] b,
                                      input logic [35:0] p);
      if (q.indirect) return p[12*q.ptr_sel +: 12];
      if (q.full) return q.full_addr;
      if (q.access) return (q.offset < AB) ? {4'h0, q.offset} : {4'hf, q.offset};
      return {b, q.offset};
   endfunction : ea
   // Word index executed after word f under the pending program change
   function automatic logic [11:0] nxt(input logic [11:0] f);
      case (br.kind)
         CH_ABSOLUTE: return br.word_target[11:0];
         // The counter already points past the prefetched word when a branch lands
         CH_RELATIVE: return f + 12'h2 + 12'(signed'(br.offset));
         CH_PCL:      return {hh[4:0], br.pcl_value[7:1]};
         CH_SKIP:     return f + 12'h2;
         default:     return f + 12'h1;
      endcase
   endfunction : nxt
   // ----------
   // Monitor and decoder, all on the falling edge to stay clear of sampling
   // ----------
   always @(negedge clk) begin
      if (!rst) begin
         cyc++;
         if (cyc > 2) check(ph, {ph_q[2:0], ph_q[3]});
         check(pa[0], 1'b0);
         if (pa !== pa_q && cyc - brk_c > 12) check(pa, pa_q + PC_STEP);
         if (op_due) check(op, exp_op);
         op_due = (rd_o === 1'b1);
         ex_a = ea(dq1, bank1, ptrs1);
         if (rd_o === 1'b1) begin
            check(dq1.rd, 1'b1);
            check(ra, ex_a);
            if (rd_ph < 0) rd_ph = cyc % 4;
            check(cyc % 4, rd_ph);
            exp_op = (ex_a >= GENERAL_PURPOSE_REGS && ex_a < SFR_BASE) ? ZERO_BYTE : mem_u.ram[ex_a];
         end
         if (wr_o === 1'b1) begin
            check(dq1.wr, 1'b1);
            check({ra, wd}, {ex_a, dq1.wdata});
            if (rd_ph >= 0) check(cyc % 4, (rd_ph + 2) % 4);
         end
      end
      if (!rst && xv === 1'b1 && il !== last_w) begin
         n_exec++;
         if (n_exec > 1) begin
            check(il, exp_word(exp_f));
            check(cyc - last_c, gap);
            if (sec_f >= 0) check(so, sec_f);
         end
         last_w = il;
         last_c = cyc;
         {hh, uh, bank} = 17'($random(seed));
         ptrs = 36'({$random(seed), $random(seed)});
         dq = data_req_t'(35'({$random(seed), $random(seed)}));
         dq.access = (dq.offset[1:0] == 2'h1);
         dq.indirect = (dq.offset[1:0] == 2'h2);
         dq.full = (dq.offset[1:0] == 2'h3);
         if (dq.ptr_sel == 2'h3) dq.ptr_sel = 2'h1;
         br = branch_req_t'(43'({$random(seed), $random(seed)}));
         br.kind = CH_NONE;
         br.two_word = 1'b0;
         br.pcl_value[0] = 1'b0;
         if (br.offset == 11'h7fe) br.offset = 11'h0;
         // Never branch from either word of a two-word pair
         if (il[3:0] < 4'h6 && br.word_target[2:0] == 3'h0) begin
            br.kind = kinds[nb % 4];
            nb++;
         end
         gap = (br.kind == CH_NONE) ? 4 : 8;
         if (br.kind != CH_NONE) brk_c = cyc;
         exp_f = nxt(il[11:0]);
         // A second word reached on its own fills a slot as a no-op but hands over its bits
         sec_f = -1;
         if (exp_f[3:0] == 4'h7) begin
            sec_f = int'(exp_f);
            exp_f = exp_f + 12'h1;
            gap = gap + 4;
         end
      end
      // Requests as the next edge samples them explain the strobes seen after it
      ph_q = ph;
      pa_q = pa;
      dq1 = dq;
      bank1 = bank;
      ptrs1 = ptrs;
   end
   // ----------
   // Main sequence
   // ----------
   initial begin
      seed = 41220;
      kinds = '{CH_ABSOLUTE, CH_RELATIVE, CH_PCL, CH_SKIP};
      rst = 1'b1;
      tbl_rd = 1'b0;
      {hh, uh, bank, ptrs, tp} = '0;
      br = '0;
      dq = '0;
      last_w = 16'h0;
      op_due = 1'b0;
      rd_ph = -1;
      sec_f = -1;
      repeat (4) @(negedge clk);
      check({ph, xv, rd_o, wr_o}, 7'h08);
      rst <= 1'b0;
      repeat (3000) @(negedge clk);
      check(n_exec >= 375, 1'b1);
      // Table reads at random byte addresses, odd and even alike
      for (int i = 0; i < 6; i++) begin
         tp <= 21'($random(seed));
         tbl_rd <= 1'b1;
         repeat (12) @(negedge clk);
         tbl_rd <= 1'b0;
         repeat (2) @(negedge clk);
         tw = exp_word(tp[12:1]);
         check(tl, tp[0] ? tw[15:8] : tw[7:0]);
      end
      summarize();
   end
   // Watchdog well past the expected 3100 cycles
   initial begin
      #150000;
      n_mismatch++;
      $display("BAD %0t run did not finish", $time);
      summarize();
   end
endmodule : cpu_fetch_pipeline_and_memory_map_tb
